// ==== hdl/nvm_cmd_regs.sv ====
// Register front end for nonvolatile reads and command strobes.
// Assumes an Avalon-MM master on i_core_clk and a nonvolatile array
// that returns the addressed byte the cycle after its read strobe.
// Function
// - Seven-bit read-write address, resets zero
// - Read-only byte from last fetch
// - Fetch bit launches machine; busy while active
// - Bit 7 starts one supply conversion
// - Bit 6 preloads next conversion unfiltered
// - Bit 5 zeroes all charge counters
// - Bit 4 starts charge-counter calibration
// - Bit 2 reloads defaults from array
// - Reload keeps enabled converters enabled
// - Bit 0 clears registers, then reloads
// - Modes read zero between clear, reload
module nvm_cmd_regs (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire nvm_cmd_pkg::avmm_req_t i_avmm,
  output nvm_cmd_pkg::avmm_rsp_t o_avmm,
  input wire logic [7:0] i_nvm_data,
  input wire logic i_reload_done,
  output nvm_cmd_pkg::nvm_req_t o_nvm,
  output nvm_cmd_pkg::cmd_strobe_t o_strobe,
  output logic o_regs_clear,
  output logic o_regs_load
);
  import nvm_cmd_pkg::*;

  blk_state_t s_r;
  blk_state_t s_nxt;
  logic sel_write;
  logic sel_read;
  logic [7:0] cmd_bits;

  // Word decode on the byte address, shared by read and write
  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    return a == ofs;
  endfunction

  // Low byte lane only; wider lanes carry nothing
  assign cmd_bits = i_avmm.byteenable[0] ? i_avmm.writedata[7:0] : 8'h00;
  // Accept each request exactly once: the previous cycle answered it
  assign sel_write = i_avmm.write && !s_r.ack_done;
  assign sel_read = i_avmm.read && !s_r.ack_done;

  // Next-state logic for registers, strobes and sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.strobe = '0;
    s_nxt.nvm.rd = 1'b0;
    s_nxt.regs_clear = 1'b0;
    s_nxt.regs_load = 1'b0;
    s_nxt.ack_done = 1'b0;
    s_nxt.rsp.waitrequest = 1'b1;
    s_nxt.rsp.readdatavalid = 1'b0;

    // Bus answer: one wait cycle, then waitrequest low for a single edge
    if (sel_write || sel_read) begin
      s_nxt.ack_done = 1'b1;
      s_nxt.rsp.waitrequest = 1'b0;
      s_nxt.rsp.readdatavalid = sel_read;
      s_nxt.rsp.readdata = UNMAPPED_VALUE;
      if (sel_read) begin
        if (hit(i_avmm.address, ADDR_OFS)) begin
          s_nxt.rsp.readdata = {25'h0, s_r.addr};
        end else if (hit(i_avmm.address, RDATA_OFS)) begin
          s_nxt.rsp.readdata = {24'h0, s_r.rdata};
        end else if (hit(i_avmm.address, STATCTRL_OFS)) begin
          // Fetch bit reads back as busy, since it self-clears
          s_nxt.rsp.readdata = {28'h0, s_r.busy, s_r.busy, 2'b00};
        end
        // Command word falls through and reads zero
      end
    end

    // Register writes; reserved bits are dropped, not stored
    if (sel_write && hit(i_avmm.address, ADDR_OFS)
        && i_avmm.byteenable[0]) begin
      s_nxt.addr = i_avmm.writedata[6:0] & ADDR_MASK;
    end

    // Command strobes, one cycle each
    if (sel_write && hit(i_avmm.address, CMD_OFS)) begin
      s_nxt.strobe.adc_start = cmd_bits[CMD_ADC_START];
      s_nxt.strobe.adc_preload = cmd_bits[CMD_ADC_PRELOAD];
      s_nxt.strobe.charge_counter_clear = cmd_bits[CMD_CC_CLEAR];
      s_nxt.strobe.charge_cal_launch = cmd_bits[CMD_CAL_LAUNCH];
    end

    // Sequencer: fetch, reload, full reset share one machine
    unique case (s_r.state)
      ST_IDLE: begin
        s_nxt.cnt = '0;
        if (sel_write && hit(i_avmm.address, CMD_OFS)
            && cmd_bits[CMD_FULL_RESET]) begin
          s_nxt.strobe.full_reset = 1'b1;
          s_nxt.regs_clear = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.reload_kind = 1'b1;
          s_nxt.state = ST_CLEAR;
        end else if (sel_write && hit(i_avmm.address, CMD_OFS)
            && cmd_bits[CMD_RELOAD]) begin
          // No clear step: enabled converters are just repainted
          s_nxt.strobe.defaults_reload = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.reload_kind = 1'b0;
          s_nxt.state = ST_RELOAD;
        end else if (sel_write && hit(i_avmm.address, STATCTRL_OFS)
            && cmd_bits[FETCH_BIT]) begin
          s_nxt.nvm.rd = 1'b1;
          s_nxt.nvm.addr = s_r.addr;
          s_nxt.busy = 1'b1;
          s_nxt.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == CNT_W'(FETCH_SAMPLE)) begin
          s_nxt.rdata = i_nvm_data;
        end
        if (s_r.cnt == CNT_W'(FETCH_CYCLES - 1)) begin
          s_nxt.state = ST_DONE;
        end
      end
      ST_CLEAR: begin
        // Mode fields stay zero while reload runs
        s_nxt.regs_clear = 1'b1;
        s_nxt.state = ST_RELOAD;
      end
      ST_RELOAD: begin
        s_nxt.regs_clear = s_r.reload_kind;
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (i_reload_done || s_r.cnt == CNT_W'(RELOAD_CYCLES - 1)) begin
          s_nxt.regs_load = 1'b1;
          s_nxt.regs_clear = 1'b0;
          s_nxt.state = ST_DONE;
        end
      end
      ST_DONE: begin
        s_nxt.busy = 1'b0;
        s_nxt.cnt = '0;
        s_nxt.state = ST_IDLE;
      end
    endcase

    // A full reset also clears this block's own registers
    if (s_r.state == ST_CLEAR) begin
      s_nxt.addr = ADDR_RESET;
      s_nxt.rdata = RDATA_RESET;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{state: ST_IDLE, rsp: '{readdata: 32'h0000_0000,
               waitrequest: 1'b1, readdatavalid: 1'b0}, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign o_avmm = s_r.rsp;
  assign o_nvm = s_r.nvm;
  assign o_strobe = s_r.strobe;
  assign o_regs_clear = s_r.regs_clear;
  assign o_regs_load = s_r.regs_load;

  // Property helpers: plain wires, nothing here is registered
  logic accept;
  logic cmd_write;
  logic cmd_read;
  logic stat_read;
  logic data_read;
  logic addr_read;
  logic fetch_write;
  logic addr_write;
  logic any_strobe;
  logic rdata_capture;
  assign accept = sel_write || sel_read;
  assign cmd_write = sel_write && hit(i_avmm.address, CMD_OFS);
  assign cmd_read = sel_read && hit(i_avmm.address, CMD_OFS);
  assign stat_read = sel_read && hit(i_avmm.address, STATCTRL_OFS);
  assign data_read = sel_read && hit(i_avmm.address, RDATA_OFS);
  assign addr_read = sel_read && hit(i_avmm.address, ADDR_OFS);
  assign fetch_write = sel_write && hit(i_avmm.address, STATCTRL_OFS)
      && cmd_bits[FETCH_BIT];
  assign addr_write = sel_write && hit(i_avmm.address, ADDR_OFS)
      && i_avmm.byteenable[0];
  assign any_strobe = (o_strobe != '0);
  assign rdata_capture = (s_r.state == ST_FETCH)
      && (s_r.cnt == CNT_W'(FETCH_SAMPLE));

  // Waitrequest low for exactly one edge, then high again
  sequence answer_s;
    !o_avmm.waitrequest ##1 o_avmm.waitrequest;
  endsequence

  // Busy across the whole fetch window, then idle
  sequence fetch_span_s;
    s_r.busy [*5] ##1 !s_r.busy;
  endsequence

  // Clear level first, own registers back at reset value next
  sequence clear_step_s;
    o_regs_clear ##1 (o_regs_clear && s_r.addr == ADDR_RESET
        && s_r.rdata == RDATA_RESET);
  endsequence

  // Load pulse lands in the closing state, busy drops after it
  sequence load_step_s;
    s_r.state == ST_DONE ##1 (!o_regs_load && !s_r.busy);
  endsequence

  // Properties on what this block drives, all on the core clock

  // A longer low phase would let the master finish a transfer twice
  bus_answer_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    accept |=> answer_s)
    else $error("bus answer is not one low waitrequest edge");

  // Waitrequest never drops on its own
  wait_origin_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !o_avmm.waitrequest |-> $past(accept))
    else $error("waitrequest low with no request taken");

  // Read data valid only on the answer edge of a read
  read_valid_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_avmm.readdatavalid |-> !o_avmm.waitrequest && $past(sel_read))
    else $error("readdatavalid outside a read answer");

  // Address register reads back what it holds
  addr_read_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    addr_read |=> o_avmm.readdata == {25'h0, $past(s_r.addr)})
    else $error("address readback differs from register");

  // Address write lands, unless a full reset clears it
  addr_write_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    addr_write && s_r.state != ST_CLEAR
    |=> s_r.addr == $past(i_avmm.writedata[6:0]))
    else $error("address write did not land");

  // Address changes only by a write or a full reset
  addr_hold_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !addr_write && s_r.state != ST_CLEAR |=> $stable(s_r.addr))
    else $error("address changed with no write");

  // Fetched byte reads back as held
  data_read_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    data_read |=> o_avmm.readdata == {24'h0, $past(s_r.rdata)})
    else $error("fetched byte readback differs");

  // Array byte captured on the sampling step of a fetch
  fetch_capture_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    rdata_capture |=> s_r.rdata == $past(i_nvm_data))
    else $error("fetched byte not captured");

  // Fetched byte holds between fetches
  rdata_hold_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !rdata_capture && s_r.state != ST_CLEAR |=> $stable(s_r.rdata))
    else $error("fetched byte changed outside a fetch");

  // Status read shows the busy flag
  busy_read_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    stat_read |=> o_avmm.readdata[BUSY_BIT] == $past(s_r.busy))
    else $error("status read does not show busy");

  // Fetch bit from idle raises the read strobe and busy
  fetch_launch_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    fetch_write && s_r.state == ST_IDLE |=> o_nvm.rd && s_r.busy)
    else $error("fetch command did not launch");

  // Busy covers the whole fetch window
  fetch_busy_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_nvm.rd |-> fetch_span_s)
    else $error("busy did not span the fetch");

  // A fetch while busy is dropped, not queued
  fetch_refused_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    fetch_write && s_r.state != ST_IDLE |=> !o_nvm.rd)
    else $error("fetch accepted while busy");

  // Analog and counter strobes come only from a command write
  strobe_origin_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (any_strobe && !o_strobe.defaults_reload && !o_strobe.full_reset)
    |-> $past(cmd_write))
    else $error("strobe with no command write");

  // Reload strobe goes with the reload state and busy
  reload_strobe_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_strobe.defaults_reload |-> s_r.state == ST_RELOAD && s_r.busy)
    else $error("reload strobe outside the reload step");

  // Load is one pulse that ends the sequence
  load_pulse_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_regs_load |-> load_step_s)
    else $error("load pulse did not close the sequence");

  // Plain reload never forces registers to zero
  reload_keeps_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_r.state == ST_RELOAD && !s_r.reload_kind |-> !o_regs_clear)
    else $error("plain reload cleared registers");

  // Full reset clears first, own registers included
  reset_clear_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_strobe.full_reset |-> clear_step_s)
    else $error("full reset did not clear registers");

  // Clear level ends only with the load pulse
  load_after_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(o_regs_clear) |-> o_regs_load)
    else $error("clear released without a load");

  // Reload never outlasts its time limit
  reload_bound_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_r.state == ST_RELOAD |-> s_r.cnt < CNT_W'(RELOAD_CYCLES))
    else $error("reload ran past its limit");

  // Every command strobe lasts one cycle
  strobe_single_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    any_strobe |=> !any_strobe)
    else $error("command strobe longer than one cycle");

  // Command word reads back as zero
  cmd_read_zero_a: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    cmd_read |=> o_avmm.readdata == '0)
    else $error("command word did not read zero");

endmodule

// ==== pkg/nvm_cmd_pkg.sv ====
// Package for the nonvolatile-access and command-strobe block.
// Assumes a single core clock and an Avalon-MM slave with waitrequest.
package nvm_cmd_pkg;

  // Register byte offsets (word index = printed offset, byte addr = 4x)
  localparam logic [7:0] ADDR_IDX = 8'h0b;
  localparam logic [7:0] RDATA_IDX = 8'h0c;
  localparam logic [7:0] STATCTRL_IDX = 8'h0e;
  localparam logic [7:0] CMD_IDX = 8'h10;
  localparam logic [9:0] ADDR_OFS = 10'h02c;
  localparam logic [9:0] RDATA_OFS = 10'h030;
  localparam logic [9:0] STATCTRL_OFS = 10'h038;
  localparam logic [9:0] CMD_OFS = 10'h040;

  // Field positions
  localparam int FETCH_BIT = 2;
  localparam int BUSY_BIT = 3;
  localparam int CMD_ADC_START = 7;
  localparam int CMD_ADC_PRELOAD = 6;
  localparam int CMD_CC_CLEAR = 5;
  localparam int CMD_CAL_LAUNCH = 4;
  localparam int CMD_RELOAD = 2;
  localparam int CMD_FULL_RESET = 0;

  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] CMD_MASK = 8'hf5;
  localparam logic [6:0] ADDR_MASK = 7'h7f;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RELOAD_US = 400;
  localparam int RELOAD_CYCLES = (RELOAD_US * (CLK_HZ / 1_000_000));
  localparam int FETCH_CYCLES = 4;
  // Array byte is taken one cycle after the read strobe, not with it
  localparam int FETCH_SAMPLE = 1;
  localparam int CNT_W = 14;

  // One-hot sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_CLEAR = 5'b00100,
    ST_RELOAD = 5'b01000,
    ST_DONE = 5'b10000
  } seq_state_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic readdatavalid;
  } avmm_rsp_t;

  // Command strobes toward the analog and counter blocks
  typedef struct packed {
    logic adc_start;
    logic adc_preload;
    logic charge_counter_clear;
    logic charge_cal_launch;
    logic defaults_reload;
    logic full_reset;
  } cmd_strobe_t;

  // Nonvolatile array access port
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
  } nvm_req_t;

  // Complete block state
  typedef struct packed {
    seq_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [6:0] addr;
    logic [7:0] rdata;
    logic busy;
    logic reload_kind;
    logic regs_clear;
    logic regs_load;
    cmd_strobe_t strobe;
    nvm_req_t nvm;
    avmm_rsp_t rsp;
    logic ack_done;
  } blk_state_t;

endpackage

// ==== bench/tb_top.sv ====
// Self-checking bench for the nonvolatile-access and command registers.
// Assumes the block answers each Avalon-MM access after one wait cycle.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_cmd_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  avmm_req_t av = '0;
  avmm_rsp_t rsp;
  logic [7:0] nvm_data = 8'h00;
  logic reload_done = 1'b0;
  nvm_req_t nvm;
  cmd_strobe_t strb;
  cmd_strobe_t strb_seen;
  logic regs_clear;
  logic regs_load;
  logic clr_seen = 1'b0;
  logic [31:0] rd_val;
  logic rdv_val;
  int rd_cnt = 0;
  int error_cnt = 0;
  int num_checks = 0;

  always #25 i_core_clk = ~i_core_clk;

  // Array stand-in: byte depends on address so a wrong fetch shows
  always @(posedge i_core_clk) begin
    nvm_data <= {1'b1, nvm.addr} ^ 8'h3c;
    if (regs_clear === 1'b1) clr_seen <= 1'b1;
    if (nvm.rd === 1'b1) rd_cnt <= rd_cnt + 1;
  end

  nvm_cmd_regs i_nvm_cmd_regs (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avmm(av), .o_avmm(rsp),
    .i_nvm_data(nvm_data), .i_reload_done(reload_done), .o_nvm(nvm),
    .o_strobe(strb), .o_regs_clear(regs_clear), .o_regs_load(regs_load));

  task final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task timeout(input string nm);
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    error_cnt++;
    final_report();
  endtask

  // One access held until waitrequest low; idle edge after release
  task xfer(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    av <= '{address: a, read: ~wr, write: wr, writedata: {24'h0, d},
            byteenable: 4'h1};
    do begin
      @(posedge i_core_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 40);
    if (rsp.waitrequest !== 1'b0) timeout("waitrequest");
    rd_val = rsp.readdata;
    rdv_val = rsp.readdatavalid;
    strb_seen = strb;
    av <= '0;
    @(posedge i_core_clk);
  endtask

  task rdchk(input logic [9:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 8'h00);
    chk(nm, exp, rd_val);
    chk({nm, " valid"}, 32'h1, 32'(rdv_val));
  endtask

  // Bounded wait on clear level (sel 0) or load pulse (sel 1)
  task wait_hi(input logic sel);
    int n;
    n = 0;
    while ((sel ? regs_load : regs_clear) !== 1'b1 && n < 100) begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 100) timeout("regs handshake");
  endtask

  task pulse_done();
    reload_done <= 1'b1;
    @(posedge i_core_clk);
    reload_done <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    // Reset values, write-only and unmapped places
    rdchk(ADDR_OFS, 32'h0, "addr reset");
    rdchk(RDATA_OFS, 32'h0, "rdata reset");
    rdchk(STATCTRL_OFS, 32'h0, "statctrl reset");
    rdchk(CMD_OFS, 32'h0, "cmd reads zero");
    xfer(1'b1, 10'h3fc, 8'hff);
    rdchk(10'h3fc, UNMAPPED_VALUE, "unmapped");
    xfer(1'b1, ADDR_OFS, 8'h5a);
    rdchk(ADDR_OFS, 32'h5a, "addr");
    // Fetch, poll busy, then take the addressed byte
    xfer(1'b1, STATCTRL_OFS, 8'h04);
    xfer(1'b0, STATCTRL_OFS, 8'h00);
    chk("busy", 32'h1, 32'(rd_val[3]));
    for (int k = 0; k < 20 && rd_val[3] !== 1'b0; k++) begin
      xfer(1'b0, STATCTRL_OFS, 8'h00);
    end
    chk("busy end", 32'h0, 32'(rd_val[3]));
    rdchk(RDATA_OFS, 32'({1'b1, 7'h5a} ^ 8'h3c), "rdata");
    chk("fetch pulses", 32'h1, rd_cnt);
    // Strobe bits 7 to 4, one pulse each
    for (int b = 7; b >= 4; b--) begin
      xfer(1'b1, CMD_OFS, 8'h01 << b);
      chk("strobe", 32'(6'h20 >> (7 - b)), 32'(strb_seen));
      chk("strobe ends", 32'h0, 32'(strb));
    end
    // Reload: no clearing of registers on the way
    clr_seen <= 1'b0;
    xfer(1'b1, CMD_OFS, 8'h04);
    chk("reload strobe", 32'h02, 32'(strb_seen));
    xfer(1'b0, STATCTRL_OFS, 8'h00);
    chk("reload busy", 32'h1, 32'(rd_val[3]));
    // Fetch while the reload runs must be dropped
    xfer(1'b1, STATCTRL_OFS, 8'h04);
    chk("fetch refused", 32'h1, rd_cnt);
    pulse_done();
    wait_hi(1'b1);
    chk("no clear in reload", 32'h0, 32'(clr_seen));
    // Full reset: clear level before the load pulse
    xfer(1'b1, CMD_OFS, 8'h01);
    chk("reset strobe", 32'h01, 32'(strb_seen));
    wait_hi(1'b0);
    chk("load after clear", 32'h0, 32'(regs_load));
    pulse_done();
    wait_hi(1'b1);
    repeat (2) @(posedge i_core_clk);
    chk("clear released", 32'h0, 32'(regs_clear));
    rdchk(ADDR_OFS, 32'h0, "addr cleared");
    rdchk(RDATA_OFS, 32'h0, "rdata cleared");
    final_report();
  end
endmodule
